// ---- usart_core.sv ----
`timescale 1ns/1ps
module usart_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic serial_input_pin,
  output logic serial_output_pin,
  input wire logic transfer_clock_in,
  output logic transfer_clock_out,
  output logic transfer_clock_oe
);
  logic [7:0] baud_divisor_low;
  logic [3:0] baud_divisor_high;
  logic [7:0] frame_control_register;
  logic double_speed_bit;
  logic transfer_clock_direction;
  logic transmit_complete_flag;
  logic receive_complete_flag;
  logic frame_error_flag;
  logic parity_error_flag;
  logic [8:0] tx_hold;
  logic tx_hold_full;
  logic [8:0] rx_data;
  logic tick;
  logic xrise;
  logic xfall;
  logic xlevel;
  logic rxd_s1;
  logic rxd_s2;
  logic rxd_s3;
  logic rxd;
  usart_cfg_pkg::clk_mode_t mode;
  usart_cfg_pkg::frame_fmt_t fmt;
  logic sync_mode_select;
  logic [3:0] div_top;
  logic [3:0] mid_point;
  logic tx_step;
  logic rx_step;

  assign sync_mode_select = frame_control_register[usart_cfg_pkg::ctl_sync_bit];
  // One format shared by both directions; changing it mid-frame garbles both.
  assign fmt.polarity = frame_control_register[usart_cfg_pkg::ctl_polarity_bit];
  assign fmt.stop_two = frame_control_register[usart_cfg_pkg::ctl_stop_bit];
  assign fmt.parity_on = frame_control_register[usart_cfg_pkg::ctl_parity_lsb + 1];
  assign fmt.parity_odd = frame_control_register[usart_cfg_pkg::ctl_parity_lsb];
  // Size codes 0..3 give 5..8 bits; every code from 4 up selects 9 bits.
  assign fmt.data_bits = frame_control_register[2] ? 4'h9 :
    usart_cfg_pkg::min_data_bits + {2'b00, frame_control_register[1:0]};

  always_comb begin
    if (!sync_mode_select) begin
      // Double speed matters only when asynchronous.
      mode = double_speed_bit ? usart_cfg_pkg::mode_double : usart_cfg_pkg::mode_async;
    end else begin
      mode = transfer_clock_direction ? usart_cfg_pkg::mode_master :
        usart_cfg_pkg::mode_slave;
    end
  end

  always_comb begin
    unique case (mode)
      usart_cfg_pkg::mode_async: begin
        div_top = usart_cfg_pkg::div_normal;
        mid_point = usart_cfg_pkg::mid_normal;
      end
      usart_cfg_pkg::mode_double: begin
        div_top = usart_cfg_pkg::div_double;
        mid_point = usart_cfg_pkg::mid_double;
      end
      usart_cfg_pkg::mode_master, usart_cfg_pkg::mode_slave: begin
        div_top = usart_cfg_pkg::div_sync;
        mid_point = usart_cfg_pkg::mid_sync;
      end
    endcase
  end

  baud_gen u_baud (
    .clock(clock),
    .rst_n(rst_n),
    .divisor({baud_divisor_high, baud_divisor_low}),
    .reload(wr && addr == usart_cfg_pkg::addr_divisor_low),
    .tick(tick)
  );

  clk_sync_edge u_xck (
    .clock(clock),
    .rst_n(rst_n),
    .pin(transfer_clock_in),
    .rise(xrise),
    .fall(xfall),
    .level(xlevel)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_s3 <= 1'b1;
      rxd <= 1'b1;
    end else begin
      rxd_s1 <= serial_input_pin;
      rxd_s2 <= rxd_s1;
      rxd_s3 <= rxd_s2;
      if (rxd_s2 == rxd_s3) begin
        rxd <= rxd_s3;
      end
    end
  end

  // Master clock: toggles on each baud tick, giving a divide by two.
  logic xck_int;
  logic xck_change;
  logic xck_sample;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xck_int <= 1'b0;
    end else if (mode == usart_cfg_pkg::mode_master && tick) begin
      xck_int <= !xck_int;
    end else if (mode != usart_cfg_pkg::mode_master) begin
      xck_int <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transfer_clock_out <= 1'b0;
      transfer_clock_oe <= 1'b0;
    end else begin
      // The pin takes the toggled level at once, so it moves on the same edge as the data.
      transfer_clock_out <= (mode == usart_cfg_pkg::mode_master) ?
        (xck_int ^ tick ^ fmt.polarity) : 1'b0;
      transfer_clock_oe <= (mode == usart_cfg_pkg::mode_master);
    end
  end

  // Data changes on one edge and is sampled on the other.
  always_comb begin
    if (mode == usart_cfg_pkg::mode_master) begin
      // The internal clock rising is the change edge; polarity only inverts the pin.
      xck_change = tick && !xck_int;
      xck_sample = tick && xck_int;
    end else begin
      // Slave edges arrive a few cycles late, so the peer must stay below a quarter rate.
      xck_change = fmt.polarity ? xfall : xrise;
      xck_sample = fmt.polarity ? xrise : xfall;
    end
  end

  // Transmitter.
  logic [3:0] tx_div;
  logic [3:0] tx_pos;
  logic [3:0] tx_last;
  logic [8:0] tx_shift;
  logic tx_par;
  logic tx_busy;
  assign tx_last = fmt.data_bits + {3'b000, fmt.parity_on} + {3'b000, fmt.stop_two};
  assign tx_step = sync_mode_select ? xck_change : (tick && tx_div == 4'h0);

  always_ff @(posedge clock) begin
    if (!rst_n || sync_mode_select) begin
      tx_div <= 4'h0;
    end else if (tick) begin
      tx_div <= (tx_div == 4'h0) ? div_top : tx_div - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_pos <= 4'h0;
      tx_shift <= 9'h000;
      tx_par <= 1'b0;
      serial_output_pin <= 1'b1;
    end else if (tx_step) begin
      if (!tx_busy) begin
        if (tx_hold_full) begin
          tx_busy <= 1'b1;
          tx_pos <= 4'h0;
          tx_shift <= tx_hold;
          tx_par <= fmt.parity_odd;
          serial_output_pin <= 1'b0;
        end else begin
          serial_output_pin <= 1'b1;
        end
      end else begin
        tx_pos <= tx_pos + 4'h1;
        if (tx_pos < fmt.data_bits) begin
          serial_output_pin <= tx_shift[0];
          tx_par <= tx_par ^ tx_shift[0];
          tx_shift <= {1'b0, tx_shift[8:1]};
        end else if (fmt.parity_on && tx_pos == fmt.data_bits) begin
          serial_output_pin <= tx_par;
        end else begin
          serial_output_pin <= 1'b1;
        end
        if (tx_pos == tx_last) begin
          tx_busy <= 1'b0;
        end
      end
    end
  end

  // Receiver.
  logic [3:0] rx_cnt;
  logic [3:0] rx_pos;
  logic [8:0] rx_shift;
  logic rx_par;
  logic rx_busy;
  logic rx_sample;
  logic rx_done;
  logic rx_ferr;
  logic rx_perr;
  assign rx_step = sync_mode_select ? xck_sample : tick;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= 4'h0;
      rx_pos <= 4'h0;
      rx_shift <= 9'h000;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
      rx_perr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (rx_step) begin
        if (!rx_busy) begin
          if (!rxd) begin
            rx_busy <= 1'b1;
            rx_cnt <= 4'h0;
            // A synchronous start is taken on a sample edge, so the next edge holds data bit 0.
            rx_pos <= sync_mode_select ? 4'h1 : 4'h0;
            rx_par <= fmt.parity_odd;
            rx_shift <= 9'h000;
          end
        end else if (rx_sample) begin
          rx_cnt <= 4'h0;
          rx_pos <= rx_pos + 4'h1;
          if (rx_pos == 4'h0) begin
            // A start bit that is high again at its middle was only noise.
            if (rxd) begin
              rx_busy <= 1'b0;
            end
          end else if (rx_pos <= fmt.data_bits) begin
            rx_shift[rx_pos - 4'h1] <= rxd;
            rx_par <= rx_par ^ rxd;
          end else if (fmt.parity_on && rx_pos == fmt.data_bits + 4'h1) begin
            rx_perr <= rx_par ^ rxd;
          end else begin
            // Only the first stop bit is looked at; a second one passes unseen.
            rx_ferr <= !rxd;
            rx_done <= 1'b1;
            rx_busy <= 1'b0;
            if (!fmt.parity_on) begin
              rx_perr <= 1'b0;
            end
          end
        end else begin
          rx_cnt <= rx_cnt + 4'h1;
        end
      end
    end
  end
  // Synchronous start is seen on a sample edge, so the first data bit follows directly.
  assign rx_sample = sync_mode_select ? 1'b1 :
    (rx_pos == 4'h0 ? rx_cnt == mid_point : rx_cnt == div_top);

  // Register file.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      baud_divisor_low <= 8'h00;
      baud_divisor_high <= 4'h0;
      frame_control_register <= usart_cfg_pkg::frame_control_reset;
      double_speed_bit <= 1'b0;
      transfer_clock_direction <= 1'b0;
    end else if (wr) begin
      unique case (addr)
        usart_cfg_pkg::addr_divisor_low: baud_divisor_low <= wdata;
        usart_cfg_pkg::addr_divisor_high: baud_divisor_high <= wdata[3:0];
        usart_cfg_pkg::addr_frame_control: frame_control_register <= wdata;
        usart_cfg_pkg::addr_status_control: begin
          double_speed_bit <= wdata[usart_cfg_pkg::sta_double_bit];
          transfer_clock_direction <= wdata[usart_cfg_pkg::sta_dir_bit];
        end
        default: begin
        end
      endcase
    end
  end

  logic tx_wr;
  logic tx_taken;
  assign tx_wr = wr && addr == usart_cfg_pkg::addr_data;
  assign tx_taken = tx_step && !tx_busy && tx_hold_full;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_hold <= 9'h000;
      tx_hold_full <= 1'b0;
    end else if (tx_wr) begin
      tx_hold <= {frame_control_register[2] ? baud_divisor_high[3] : 1'b0, wdata};
      tx_hold_full <= 1'b1;
    end else if (tx_taken) begin
      tx_hold_full <= 1'b0;
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle.
  logic tx_end;
  assign tx_end = tx_step && tx_busy && tx_pos == tx_last && !tx_hold_full;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transmit_complete_flag <= 1'b0;
      receive_complete_flag <= 1'b0;
      frame_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      rx_data <= 9'h000;
    end else begin
      if (tx_end) begin
        transmit_complete_flag <= 1'b1;
      end else if (wr && addr == usart_cfg_pkg::addr_status_control &&
          wdata[usart_cfg_pkg::sta_tx_done_bit]) begin
        transmit_complete_flag <= 1'b0;
      end
      if (rx_done) begin
        receive_complete_flag <= 1'b1;
        rx_data <= rx_shift;
        frame_error_flag <= rx_ferr;
        parity_error_flag <= rx_perr;
      end else if (rd && addr == usart_cfg_pkg::addr_data) begin
        receive_complete_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        usart_cfg_pkg::addr_divisor_low: rdata <= baud_divisor_low;
        usart_cfg_pkg::addr_divisor_high: rdata <= {4'h0, baud_divisor_high};
        usart_cfg_pkg::addr_frame_control: rdata <= frame_control_register;
        usart_cfg_pkg::addr_status_control: rdata <= {receive_complete_flag,
          transmit_complete_flag, !tx_hold_full, frame_error_flag, xlevel,
          parity_error_flag, double_speed_bit, transfer_clock_direction};
        usart_cfg_pkg::addr_data: rdata <= rx_data[7:0];
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// ---- usart_cfg_pkg.sv ----
// Function
// - Four clock modes chosen by sync select.
// - Clock direction picks master or slave clock.
// - Transfer clock pin idle in asynchronous mode.
// - Counter reloads at zero and low-byte write.
// - One baud tick each time counter hits zero.
// - Transmit divides ticks by 16, 8 or 2.
// - Divisor is twelve bits from two bytes.
// - Double speed halves asynchronous divider to 8.
// - Double speed ignored in synchronous mode.
// - Double speed receiver counts 8 ticks per bit.
// - Slave clock synchronised then edge detected.
// - Sample on edge opposite data change.
// - Polarity bit selects change and sample edges.
// - Frames: 5-9 data, parity option, 1-2 stops.
// - Start, data LSB first, parity, stops.
// - Size, parity, stop fields set frame format.
// - One shared format; changes corrupt transfers.
// - Frame error only when first stop zero.
// - Parity is data xor, inverted for odd.
package usart_cfg_pkg;
  localparam logic [2:0] addr_divisor_low = 3'h0;
  localparam logic [2:0] addr_divisor_high = 3'h1;
  localparam logic [2:0] addr_frame_control = 3'h2;
  localparam logic [2:0] addr_status_control = 3'h3;
  localparam logic [2:0] addr_data = 3'h4;
  localparam int ctl_sync_bit = 6;
  localparam int ctl_parity_lsb = 4;
  localparam int ctl_stop_bit = 3;
  localparam int ctl_size_lsb = 0;
  localparam int ctl_polarity_bit = 7;
  localparam int sta_rx_done_bit = 7;
  localparam int sta_tx_done_bit = 6;
  localparam int sta_frame_err_bit = 4;
  localparam int sta_parity_err_bit = 2;
  localparam int sta_double_bit = 1;
  localparam int sta_dir_bit = 0;
  localparam logic [7:0] frame_control_reset = 8'h06;
  localparam logic [3:0] div_normal = 4'hf;
  localparam logic [3:0] div_double = 4'h7;
  localparam logic [3:0] div_sync = 4'h1;
  localparam logic [3:0] mid_normal = 4'h7;
  localparam logic [3:0] mid_double = 4'h3;
  localparam logic [3:0] mid_sync = 4'h0;
  localparam logic [3:0] min_data_bits = 4'h5;
  typedef enum logic [1:0] {
    mode_async = 2'b00,
    mode_double = 2'b01,
    mode_master = 2'b10,
    mode_slave = 2'b11
  } clk_mode_t;
  typedef struct packed {
    logic polarity;
    logic stop_two;
    logic parity_on;
    logic parity_odd;
    logic [3:0] data_bits;
  } frame_fmt_t;
endpackage

// ---- baud_gen.sv ----
`timescale 1ns/1ps
module baud_gen (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [11:0] divisor,
  input wire logic reload,
  output logic tick
);
  logic [11:0] count;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= 12'h000;
      tick <= 1'b0;
    end else if (reload) begin
      count <= divisor;
      tick <= 1'b0;
    end else if (count == 12'h000) begin
      count <= divisor;
      tick <= 1'b1;
    end else begin
      count <= count - 12'h001;
      tick <= 1'b0;
    end
  end
endmodule

// ---- clk_sync_edge.sv ----
`timescale 1ns/1ps
module clk_sync_edge (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
  // Edges are judged on the agreed level, so a runt glitch shorter than a cycle is dropped.
  assign rise = (s2 == s3) && s3 && !level;
  assign fall = (s2 == s3) && !s3 && level;
endmodule

// ---- usart_core_props.sv ----
`timescale 1ns/1ps
module usart_core_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic serial_input_pin,
  input wire logic serial_output_pin,
  input wire logic transfer_clock_in,
  input wire logic transfer_clock_out,
  input wire logic transfer_clock_oe
);
  logic [7:0] fc;
  logic [1:0] st;
  logic [11:0] dv;
  logic [15:0] age, low_run, clk_run, half, bt;
  logic master;
  assign half = {4'h0, dv} + 16'h1;
  assign bt = fc[6] ? half << 1 : (st[1] ? half << 3 : half << 4);
  assign master = fc[6] && st[0];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fc <= usart_cfg_pkg::frame_control_reset;
      st <= 2'h0;
      dv <= 12'h000;
    end else if (wr && addr == 3'h0) begin
      dv[7:0] <= wdata;
    end else if (wr && addr == 3'h1) begin
      dv[11:8] <= wdata[3:0];
    end else if (wr && addr == 3'h2) begin
      fc <= wdata;
    end else if (wr && addr == 3'h3) begin
      st <= wdata[1:0];
    end
  end
  // Settings age keeps checks off the cycles where a new setting is still landing.
  always_ff @(posedge clock) begin
    if (!rst_n || (wr && addr < 3'h4)) age <= 16'h0;
    else if (age != 16'hffff) age <= age + 16'h1;
  end
  always_ff @(posedge clock) begin
    low_run <= serial_output_pin ? 16'h0 : low_run + 16'h1;
    clk_run <= $changed(transfer_clock_out) ? 16'h1 : clk_run + 16'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_read(logic [2:0] a);
    rd && addr == a;
  endsequence
  a_bit_length: assert property (
    $rose(serial_output_pin) && age > low_run && !(fc[6] && !st[0]) |-> low_run % bt == 16'h0)
    else $error("Low stretch is not whole bit times.");
  a_master_half: assert property (
    $changed(transfer_clock_out) && master && age > clk_run && clk_run < (half << 1)
    |-> clk_run == half) else $error("Master clock half period wrong.");
  a_async_quiet: assert property (
    age > 16'h3 && !fc[6] |-> !transfer_clock_oe && !transfer_clock_out)
    else $error("Clock pin active in async mode.");
  a_master_enable: assert property (age > 16'h3 |-> transfer_clock_oe == master)
    else $error("Clock pin enable wrong.");
  a_change_edge: assert property (
    $changed(serial_output_pin) && master && age > 16'h3 |-> transfer_clock_out != fc[7])
    else $error("Master data changed on the wrong edge.");
  a_read_gap: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("Read data without a read.");
  a_unmapped_zero: assert property (rd && addr > 3'h4 |=> rdata == 8'h00)
    else $error("Unmapped read not zero.");
  a_format_readback: assert property (s_read(3'h2) |=> rdata == fc)
    else $error("Frame control readback wrong.");
  a_reset_idle: assert property (disable iff (1'b0)
    !rst_n |=> serial_output_pin && !transfer_clock_oe && rdata == 8'h00)
    else $error("Outputs not idle in reset.");
endmodule
bind usart_core usart_core_props props (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_input_pin(serial_input_pin),
  .serial_output_pin(serial_output_pin), .transfer_clock_in(transfer_clock_in),
  .transfer_clock_out(transfer_clock_out), .transfer_clock_oe(transfer_clock_oe));

// ---- remote_peer.sv ----
`timescale 1ns/1ps
module remote_peer (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out,
  output logic clk_out
);
  initial begin
    line_out = 1'b1;
    clk_out = 1'b0;
  end
  // Samples mid-bit from the start edge; a second stop is never looked at.
  task automatic take(input int n, input int bt, output logic [11:0] bits);
    int i;
    bits = 12'h000;
    i = 0;
    while (line_in !== 1'b0 && i < 20000) begin
      @(posedge clock);
      i++;
    end
    repeat (bt / 2) @(posedge clock);
    for (i = 0; i < n; i++) begin
      repeat (bt) @(posedge clock);
      bits[i] = line_in;
    end
  endtask
  // Data changes with the rising clock so the device samples on the falling one.
  // The clock stands low between frames and stays well under a quarter of the system rate.
  task automatic give(input logic [11:0] bits, input int n, input int bt, input logic sync);
    logic [12:0] all;
    int i;
    all = {bits, 1'b0};
    for (i = 0; i <= n; i++) begin
      line_out <= all[i];
      clk_out <= sync;
      repeat (bt / 2) @(posedge clock);
      clk_out <= 1'b0;
      repeat (bt - bt / 2) @(posedge clock);
    end
    line_out <= 1'b1;
  endtask
endmodule

// ---- test_usart_clock_and_frame_format.sv ----
`timescale 1ns/1ps
module test_usart_clock_and_frame_format;
  typedef struct packed {
    logic [7:0] fc;
    logic [1:0] st;
    logic [7:0] dv;
    logic [8:0] d;
  } row_t;
  logic clock, rst_n, wr, rd, sin, sout, xin, xout, xoe, pclk;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int mismatches = 0;
  int n_tests = 0;
  // Sync rows keep double speed cleared.
  row_t rows [7] = '{
    '{8'h03, 2'h0, 8'h01, 9'h0a5},
    '{8'h28, 2'h0, 8'h00, 9'h013},
    '{8'h31, 2'h2, 8'h02, 9'h02c},
    '{8'h3c, 2'h2, 8'h00, 9'h0b5},
    '{8'h07, 2'h0, 8'h00, 9'h0aa},
    '{8'h43, 2'h1, 8'h03, 9'h0c3},
    '{8'hf7, 2'h1, 8'h03, 9'h055}
  };
  assign xin = xoe ? xout : pclk;
  usart_core dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_input_pin(sin), .serial_output_pin(sout), .transfer_clock_in(xin),
    .transfer_clock_out(xout), .transfer_clock_oe(xoe));
  remote_peer peer (.clock(clock), .line_in(sout), .line_out(sin), .clk_out(pclk));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
    @(posedge clock);
  endtask
  function automatic int width_of(input logic [7:0] fc);
    return (fc[2] ? 9 : fc[1:0] + 5) + fc[5] + 1;
  endfunction
  function automatic int bit_time(input logic [7:0] fc, input logic [1:0] st, input logic [7:0] dv);
    return (fc[6] ? 2 : (st[1] ? 8 : 16)) * (dv + 1);
  endfunction
  function automatic logic [11:0] framed(input logic [8:0] d, input logic [7:0] fc);
    int nb;
    logic [11:0] f;
    nb = fc[2] ? 9 : fc[1:0] + 5;
    f = {3'h0, d} & ((12'h1 << nb) - 12'h1);
    if (fc[5]) f[nb] = ^f ^ fc[4];
    f[nb + fc[5]] = 1'b1;
    return f;
  endfunction
  task automatic setup(input logic [7:0] fc, input logic [1:0] st, input logic [7:0] dv);
    wreg(3'h1, 8'h00);
    wreg(3'h0, dv);
    wreg(3'h2, fc);
    wreg(3'h3, {6'h10, st});
    repeat (3) @(posedge clock);
    check("clock enable", {11'h0, fc[6] & st[0]}, {11'h0, xoe});
  endtask
  task automatic rx_case(input logic [7:0] fc, input logic [1:0] st, input logic [7:0] dv,
      input logic [8:0] d, input logic [11:0] flip, input logic fe);
    logic [11:0] f;
    logic [7:0] s, w;
    int n;
    setup(fc, st, dv);
    f = framed(d, fc);
    n = width_of(fc);
    if (fc[3]) begin
      f[n] = 1'b1;
      n++;
    end
    peer.give(f ^ flip, n, bit_time(fc, st, dv), fc[6]);
    repeat (4) @(posedge clock);
    rreg(3'h3, s);
    rreg(3'h4, w);
    check("received", {1'b1, fe, 2'h0, d[7:0]}, {s[7], s[4], s[2], 1'b0, w});
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    test_done();
  end
  initial begin
    logic [7:0] v;
    logic [11:0] got;
    int bt;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rreg(3'h2, v);
    check("frame control", {4'h0, usart_cfg_pkg::frame_control_reset}, {4'h0, v});
    wreg(3'h6, 8'hff);
    rreg(3'h6, v);
    check("unmapped", 12'h000, {4'h0, v});
    foreach (rows[k]) begin
      setup(rows[k].fc, rows[k].st, rows[k].dv);
      bt = bit_time(rows[k].fc, rows[k].st, rows[k].dv);
      fork
        wreg(3'h4, rows[k].d[7:0]);
        peer.take(width_of(rows[k].fc), bt, got);
      join
      check("frame", framed(rows[k].d, rows[k].fc), got);
      repeat (2 * bt) @(posedge clock);
      rreg(3'h3, v);
      check("tx complete", 12'h001, {11'h0, v[6]});
    end
    rx_case(8'h23, 2'h0, 8'h01, 9'h05a, 12'h000, 1'b0);
    rx_case(8'h03, 2'h0, 8'h01, 9'h0e1, 12'h100, 1'b1);
    rx_case(8'h0b, 2'h0, 8'h00, 9'h03c, 12'h200, 1'b0);
    // A low second stop reads as a new start, so that phantom frame must run out first.
    repeat (200) @(posedge clock);
    rx_case(8'h01, 2'h2, 8'h02, 9'h02d, 12'h000, 1'b0);
    rx_case(8'h43, 2'h0, 8'h03, 9'h0c6, 12'h000, 1'b0);
    test_done();
  end
endmodule
